// ==== hdl/eema_pkg.sv ====
// constants and types shared by the eeprom module host controller
package eema_pkg;

  // pin and bus geometry
  localparam int ADDR_W = 17;
  localparam int LANES = 4;
  localparam int DATA_W = 8 * LANES;
  localparam int PAGE_LSB = 8;
  localparam int CNT_W = 20;
  localparam int BIT_TOGGLE = 6;
  localparam int BIT_POLL = 7;

  // clock rate and printed times
  localparam int CLK_MHZ = 50;
  localparam int T_WP_NS = 100;
  localparam int T_WPH_NS = 50;
  localparam int T_ACC_NS = 200;
  localparam int T_OEHP_NS = 150;
  localparam int T_BLC_US = 150;
  localparam int T_WC_MS = 10;

  // nanosecond times round up to whole cycles, microsecond and millisecond times scale exactly
  localparam int WP_CYC = (T_WP_NS * CLK_MHZ + 999) / 1000;
  localparam int WPH_CYC = (T_WPH_NS * CLK_MHZ + 999) / 1000;
  localparam int ACC_CYC = (T_ACC_NS * CLK_MHZ + 999) / 1000;
  localparam int OEHP_CYC = (T_OEHP_NS * CLK_MHZ + 999) / 1000;
  localparam int BLC_CYC = T_BLC_US * CLK_MHZ;
  localparam int WC_CYC = T_WC_MS * 1000 * CLK_MHZ;
  localparam int SYNC_LAT = 2;
  localparam int ACCEPT_LEAD = 2;

  // unlock sequence: three fixed writes, replicated on every selected lane
  localparam logic [ADDR_W-1:0] UNL_ADDR0 = 17'h00AAA;
  localparam logic [ADDR_W-1:0] UNL_ADDR1 = 17'h00555;
  localparam logic [ADDR_W-1:0] UNL_ADDR2 = 17'h00AAA;
  localparam logic [7:0] UNL_DATA0 = 8'h3C;
  localparam logic [7:0] UNL_DATA1 = 8'hC3;
  localparam logic [7:0] UNL_DATA2 = 8'h5A;
  localparam logic [1:0] UNL_STEPS = 2'h3;

  // idle pin levels
  localparam logic [LANES-1:0] LANES_OFF = 4'hF;

  typedef enum logic [3:0] {
    EEMA_IDLE, EEMA_WR_SETUP, EEMA_WR_PULSE, EEMA_WR_HOLD, EEMA_WR_RECOV,
    EEMA_PAGE, EEMA_CLOSE, EEMA_RD_ACC, EEMA_RD_REL
  } eema_state_t;

endpackage

// ==== hdl/eema_sync.sv ====
// two flip-flop synchroniser for the data pins
`timescale 1ns/1ps
module eema_sync #(
  parameter int W = 32
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic nrst,
  // asynchronous in, synchronised out
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);

  typedef struct packed {
    logic [W-1:0] meta;
    logic [W-1:0] sync;
  } eema_sync_t;

  eema_sync_t s_reg;
  eema_sync_t s_next;

  // first stage is read by the second stage only
  always_comb begin
    s_next.meta = d;
    s_next.sync = s_reg.meta;
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  assign q = s_reg.sync;

endmodule // eema_sync

// ==== hdl/eema_host.sv ====
// host controller driving the asynchronous eeprom module pins
`timescale 1ns/1ps
module eema_host #(
  parameter int BLC_CYC = eema_pkg::BLC_CYC,
  parameter int WC_CYC = eema_pkg::WC_CYC
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic nrst,
  // user request
  input wire logic req_valid,
  output logic req_ready,
  input wire logic req_write,
  input wire logic req_unlock,
  input wire logic req_last,
  input wire logic [eema_pkg::ADDR_W-1:0] req_addr,
  input wire logic [eema_pkg::LANES-1:0] req_lanes,
  input wire logic [eema_pkg::DATA_W-1:0] req_wdata,
  // user answer
  output logic rsp_valid,
  output logic rsp_err,
  output logic [eema_pkg::DATA_W-1:0] rsp_rdata,
  output logic busy,
  // module pins
  output logic [eema_pkg::ADDR_W-1:0] mem_addr,
  output logic [eema_pkg::LANES-1:0] lane_select_n,
  output logic [eema_pkg::LANES-1:0] lane_write_strobe_n,
  output logic out_enable_n,
  output logic [eema_pkg::DATA_W-1:0] data_o,
  output logic data_oe,
  input wire logic [eema_pkg::DATA_W-1:0] data_i
);

  localparam int AW = eema_pkg::ADDR_W;
  localparam int NL = eema_pkg::LANES;
  localparam int DW = eema_pkg::DATA_W;
  localparam int CW = eema_pkg::CNT_W;

  typedef struct packed {
    eema_pkg::eema_state_t st;
    logic [CW-1:0] cnt;
    logic [CW-1:0] win;
    logic [CW-1:0] tmo;
    logic [AW-eema_pkg::PAGE_LSB-1:0] page;
    logic [AW-1:0] addr;
    logic [NL-1:0] lanes;
    logic [DW-1:0] wdata;
    logic [1:0] ustep;
    logic unlock;
    logic cont;
    logic close_req;
    logic rd_poll;
    logic polled;
    logic [NL-1:0] d6_prev;
    logic [AW-1:0] maddr;
    logic [NL-1:0] sel_n;
    logic [NL-1:0] we_n;
    logic oe_n;
    logic [DW-1:0] dout;
    logic doe;
    logic rsp_valid;
    logic rsp_err;
    logic [DW-1:0] rdata;
  } eema_host_t;

  eema_host_t s_reg;
  eema_host_t s_next;
  logic [DW-1:0] din_s;
  logic [NL-1:0] d6_now;
  logic [NL-1:0] d7_now;
  logic [NL-1:0] d7_want;
  logic page_ok;
  logic uphase;
  logic [AW-1:0] cur_addr;
  logic [7:0] cur_byte;

  // legal lane patterns: all four, an aligned pair, or one lane
  function automatic logic lanes_legal(input logic [3:0] m);
    lanes_legal = (m == 4'hF) || (m == 4'h3) || (m == 4'hC) ||
                  (m == 4'h1) || (m == 4'h2) || (m == 4'h4) || (m == 4'h8);
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // data pins come from outside the clock domain
  eema_sync #(.W(DW)) u_din_sync (
    .core_clk(core_clk),
    .nrst(nrst),
    .d(data_i),
    .q(din_s)
  );

  // per-lane status bits of the last captured read, and the poll bit expected from the write data
  for (genvar i = 0; i < NL; i++) begin : g_lane_bits
    assign d6_now[i] = s_reg.rdata[8*i+eema_pkg::BIT_TOGGLE];
    assign d7_now[i] = s_reg.rdata[8*i+eema_pkg::BIT_POLL];
    assign d7_want[i] = s_reg.wdata[8*i+eema_pkg::BIT_POLL];
  end

  // unlock writes use fixed words until all three are out
  assign uphase = s_reg.unlock && (s_reg.ustep != eema_pkg::UNL_STEPS);
  always_comb begin
    cur_addr = s_reg.addr;
    cur_byte = 8'h00;
    if (s_reg.ustep == 2'h0) begin
      cur_addr = eema_pkg::UNL_ADDR0;
      cur_byte = eema_pkg::UNL_DATA0;
    end else if (s_reg.ustep == 2'h1) begin
      cur_addr = eema_pkg::UNL_ADDR1;
      cur_byte = eema_pkg::UNL_DATA1;
    end else if (s_reg.ustep == 2'h2) begin
      cur_addr = eema_pkg::UNL_ADDR2;
      cur_byte = eema_pkg::UNL_DATA2;
    end
  end

  // a further load joins the open page only with margin left on the window
  assign page_ok = req_write && !req_unlock && lanes_legal(req_lanes) &&
                   (req_addr[AW-1:eema_pkg::PAGE_LSB] == s_reg.page) &&
                   (s_reg.win < CW'(BLC_CYC - eema_pkg::ACCEPT_LEAD));
  assign req_ready = (s_reg.st == eema_pkg::EEMA_IDLE) ||
                     (s_reg.st == eema_pkg::EEMA_PAGE && !s_reg.close_req && page_ok);

  ////////////////////////////////////////////////////////////////////////////
  // next state
  always_comb begin
    s_next = s_reg;
    s_next.rsp_valid = 1'b0;
    s_next.cnt = s_reg.cnt + CW'(1);
    s_next.tmo = s_reg.tmo + CW'(1);
    if (s_reg.win < CW'(BLC_CYC)) begin
      s_next.win = s_reg.win + CW'(1);
    end
    case (s_reg.st)
      eema_pkg::EEMA_IDLE: begin
        if (req_valid) begin
          s_next.addr = req_addr;
          s_next.lanes = req_lanes;
          s_next.wdata = req_wdata;
          s_next.close_req = req_last;
          s_next.cnt = '0;
          s_next.cont = 1'b0;
          if (!lanes_legal(req_lanes)) begin
            s_next.rsp_valid = 1'b1;
            s_next.rsp_err = 1'b1;
          end else if (req_write) begin
            s_next.unlock = req_unlock;
            s_next.ustep = req_unlock ? 2'h0 : eema_pkg::UNL_STEPS;
            s_next.page = req_addr[AW-1:eema_pkg::PAGE_LSB];
            s_next.st = eema_pkg::EEMA_WR_SETUP;
          end else begin
            // plain read: select and output enable fall together
            s_next.rd_poll = 1'b0;
            s_next.maddr = req_addr;
            s_next.sel_n = ~req_lanes;
            s_next.oe_n = 1'b0;
            s_next.st = eema_pkg::EEMA_RD_ACC;
          end
        end
      end
      eema_pkg::EEMA_WR_SETUP: begin
        // address, data and select are steady no later than the strobe fall
        s_next.maddr = uphase ? cur_addr : s_reg.addr;
        s_next.dout = uphase ? {NL{cur_byte}} : s_reg.wdata;
        s_next.doe = 1'b1;
        s_next.oe_n = 1'b1;
        s_next.sel_n = ~s_reg.lanes;
        s_next.we_n = ~s_reg.lanes;
        s_next.win = '0;
        s_next.cnt = '0;
        s_next.st = eema_pkg::EEMA_WR_PULSE;
      end
      eema_pkg::EEMA_WR_PULSE: begin
        // pulse far above the noise floor the device filters out
        if (s_reg.cnt == CW'(eema_pkg::WP_CYC - 1)) begin
          s_next.we_n = eema_pkg::LANES_OFF;
          s_next.st = eema_pkg::EEMA_WR_HOLD;
        end
      end
      eema_pkg::EEMA_WR_HOLD: begin
        // strobe rises first, select and data follow one cycle later
        s_next.sel_n = eema_pkg::LANES_OFF;
        s_next.doe = 1'b0;
        s_next.cnt = '0;
        s_next.st = eema_pkg::EEMA_WR_RECOV;
      end
      eema_pkg::EEMA_WR_RECOV: begin
        if (s_reg.cnt == CW'(eema_pkg::WPH_CYC - 1)) begin
          if (uphase) begin
            s_next.ustep = s_reg.ustep + 2'h1;
            s_next.st = eema_pkg::EEMA_WR_SETUP;
          end else begin
            s_next.st = eema_pkg::EEMA_PAGE;
          end
        end
      end
      eema_pkg::EEMA_PAGE: begin
        if (s_reg.close_req || s_reg.win >= CW'(BLC_CYC - eema_pkg::ACCEPT_LEAD)) begin
          s_next.st = eema_pkg::EEMA_CLOSE;
        end else if (req_valid) begin
          if (page_ok) begin
            s_next.addr = req_addr;
            s_next.lanes = req_lanes;
            s_next.wdata = req_wdata;
            s_next.close_req = req_last;
            s_next.cont = 1'b1;
            s_next.st = eema_pkg::EEMA_WR_SETUP;
          end else begin
            // any other request waits until programming has finished
            s_next.st = eema_pkg::EEMA_CLOSE;
          end
        end
      end
      eema_pkg::EEMA_CLOSE: begin
        // the page only closes once the load window has run out
        if (s_reg.win >= CW'(BLC_CYC)) begin
          s_next.rd_poll = 1'b1;
          s_next.polled = 1'b0;
          s_next.tmo = '0;
          s_next.cnt = '0;
          s_next.maddr = s_reg.addr;
          s_next.sel_n = ~s_reg.lanes;
          s_next.oe_n = 1'b0;
          s_next.st = eema_pkg::EEMA_RD_ACC;
        end
      end
      eema_pkg::EEMA_RD_ACC: begin
        // worst access time plus the synchroniser delay
        if (s_reg.cnt == CW'(eema_pkg::ACC_CYC + eema_pkg::SYNC_LAT - 1)) begin
          s_next.rdata = din_s;
          s_next.sel_n = eema_pkg::LANES_OFF;
          s_next.oe_n = 1'b1;
          s_next.cnt = '0;
          s_next.st = eema_pkg::EEMA_RD_REL;
        end
      end
      eema_pkg::EEMA_RD_REL: begin
        // output enable high long enough for the bus to float and toggle
        if (s_reg.cnt == CW'(eema_pkg::OEHP_CYC - 1)) begin
          s_next.cnt = '0;
          if (!s_reg.rd_poll) begin
            s_next.rsp_valid = 1'b1;
            s_next.rsp_err = 1'b0;
            s_next.st = eema_pkg::EEMA_IDLE;
          end else begin
            s_next.polled = 1'b1;
            s_next.d6_prev = d6_now & s_reg.lanes;
            if (s_reg.polled && ((d6_now & s_reg.lanes) == s_reg.d6_prev) &&
                ((d7_now & s_reg.lanes) == (d7_want & s_reg.lanes))) begin
              s_next.rsp_valid = 1'b1;
              s_next.rsp_err = 1'b0;
              s_next.st = eema_pkg::EEMA_IDLE;
            end else if (s_reg.tmo >= CW'(WC_CYC)) begin
              s_next.rsp_valid = 1'b1;
              s_next.rsp_err = 1'b1;
              s_next.st = eema_pkg::EEMA_IDLE;
            end else begin
              s_next.sel_n = ~s_reg.lanes;
              s_next.oe_n = 1'b0;
              s_next.st = eema_pkg::EEMA_RD_ACC;
            end
          end
        end
      end
      default: begin
        s_next.st = eema_pkg::EEMA_IDLE;
      end
    endcase
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      s_reg <= '0;
      s_reg.st <= eema_pkg::EEMA_IDLE;
      s_reg.sel_n <= eema_pkg::LANES_OFF;
      s_reg.we_n <= eema_pkg::LANES_OFF;
      s_reg.oe_n <= 1'b1;
    end else begin
      s_reg <= s_next;
    end
  end

  // pin and answer outputs straight from the state register
  assign mem_addr = s_reg.maddr;
  assign lane_select_n = s_reg.sel_n;
  assign lane_write_strobe_n = s_reg.we_n;
  assign out_enable_n = s_reg.oe_n;
  assign data_o = s_reg.dout;
  assign data_oe = s_reg.doe;
  assign rsp_valid = s_reg.rsp_valid;
  assign rsp_err = s_reg.rsp_err;
  assign rsp_rdata = s_reg.rdata;
  assign busy = (s_reg.st != eema_pkg::EEMA_IDLE);

  ////////////////////////////////////////////////////////////////////////////
  // helper logic for the checks below
  logic [CW-1:0] gap_q;
  logic [1:0] ucnt_q;
  logic we_fall;
  assign we_fall = (lane_write_strobe_n != eema_pkg::LANES_OFF) && (gap_q != '0) &&
                   (s_reg.st == eema_pkg::EEMA_WR_PULSE) && (s_reg.cnt == '0);
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      gap_q <= '1;
      ucnt_q <= 2'h0;
    end else begin
      gap_q <= we_fall ? '0 : ((gap_q == '1) ? gap_q : gap_q + CW'(1));
      if (s_reg.st == eema_pkg::EEMA_IDLE) begin
        ucnt_q <= 2'h0;
      end else if (we_fall && uphase) begin
        ucnt_q <= ucnt_q + 2'h1;
      end
    end
  end

  sequence s_strobe_low;
    (lane_write_strobe_n != eema_pkg::LANES_OFF)[*5];
  endsequence
  sequence s_strobe_release;
    (lane_write_strobe_n == eema_pkg::LANES_OFF) ##1 (lane_select_n == eema_pkg::LANES_OFF);
  endsequence

  property p_page_addr;
    @(posedge core_clk) disable iff (!nrst)
    $fell(&lane_write_strobe_n) && !uphase |->
      mem_addr[AW-1:eema_pkg::PAGE_LSB] == s_reg.page;
  endproperty
  a_page_addr: assert property (p_page_addr) else $error("page address changed in page");

  property p_load_window;
    @(posedge core_clk) disable iff (!nrst)
    $fell(&lane_write_strobe_n) && s_reg.cont |-> gap_q < CW'(BLC_CYC);
  endproperty
  a_load_window: assert property (p_load_window) else $error("byte load after window");

  property p_oe_high_write;
    @(posedge core_clk) disable iff (!nrst)
    (lane_write_strobe_n != eema_pkg::LANES_OFF) |->
      out_enable_n && ((~lane_write_strobe_n & lane_select_n) == '0);
  endproperty
  a_oe_high_write: assert property (p_oe_high_write) else $error("strobe without select");

  property p_lane_pattern;
    @(posedge core_clk) disable iff (!nrst)
    (lane_select_n != eema_pkg::LANES_OFF) |-> lanes_legal(~lane_select_n);
  endproperty
  a_lane_pattern: assert property (p_lane_pattern) else $error("illegal lane pattern");

  property p_unlock_first;
    @(posedge core_clk) disable iff (!nrst)
    $fell(&lane_write_strobe_n) && s_reg.unlock && !uphase |-> ucnt_q == 2'h3;
  endproperty
  a_unlock_first: assert property (p_unlock_first) else $error("data write before unlock");

  property p_unlock_words;
    @(posedge core_clk) disable iff (!nrst)
    $fell(&lane_write_strobe_n) && uphase && ucnt_q == 2'h0 |->
      mem_addr == eema_pkg::UNL_ADDR0 && data_o[7:0] == eema_pkg::UNL_DATA0;
  endproperty
  a_unlock_words: assert property (p_unlock_words) else $error("wrong unlock word");

  property p_wr_pulse;
    @(posedge core_clk) disable iff (!nrst)
    $fell(&lane_write_strobe_n) |-> s_strobe_low ##1 s_strobe_release;
  endproperty
  a_wr_pulse: assert property (p_wr_pulse) else $error("write pulse shape wrong");

  property p_no_contention;
    @(posedge core_clk) disable iff (!nrst)
    data_oe |-> out_enable_n ##1 (data_oe || out_enable_n);
  endproperty
  a_no_contention: assert property (p_no_contention) else $error("bus contention");

endmodule // eema_host

// ==== dv/eema_dev_model.sv ====
// behavioural model of the byte-lane eeprom module facing the host controller
`timescale 1ns/1ps
module eema_dev_model #(
  parameter int BLC_NS = 700,
  parameter int PROG_NS = 3000
) (
  // module pins
  input wire logic [16:0] mem_addr,
  input wire logic [3:0] lane_select_n,
  input wire logic [3:0] lane_write_strobe_n,
  input wire logic out_enable_n,
  input wire logic [31:0] data_o,
  input wire logic data_oe,
  output logic [31:0] data_i
);
  logic [7:0] mem [logic [18:0]];
  logic [7:0] pb [logic [18:0]];
  logic [16:0] a_lat = 17'h0;
  logic [3:0] ln_lat = 4'h0;
  logic [31:0] last_w = 32'h0;
  logic [31:0] idle_v = 32'h0;
  logic [7:0] b = 8'h0;
  logic [1:0] step = 2'h0;
  logic prot = 1'b0;
  logic prog = 1'b0;
  logic pend = 1'b0;
  logic tog = 1'b0;
  logic wr_go;
  logic rd_on;
  realtime t_fall = 0.0;
  logic [16:0] ua [3] = '{eema_pkg::UNL_ADDR0, eema_pkg::UNL_ADDR1, eema_pkg::UNL_ADDR2};
  logic [7:0] ud [3] = '{eema_pkg::UNL_DATA0, eema_pkg::UNL_DATA1, eema_pkg::UNL_DATA2};

  // status word while programming, array contents otherwise
  function automatic logic [31:0] rd_word(input logic [16:0] a, input logic p, input logic t);
    logic [31:0] w;
    w = (last_w ^ 32'h8080_8080) & 32'hBFBF_BFBF | {4{1'b0, t, 6'h0}};
    if (!p)
      for (int i = 0; i < 4; i++) w[8*i+:8] = mem.exists({a, i[1:0]}) ? mem[{a, i[1:0]}] : 8'hFF;
    return w;
  endfunction

  ////////////////////////////////////////////////////////////////
  // write and read decode from the pin levels
  assign wr_go = ((~lane_select_n & ~lane_write_strobe_n) != 4'h0) && out_enable_n;
  assign rd_on = !out_enable_n && lane_select_n != 4'hF;
  assign data_i = rd_on ? rd_word(mem_addr, prog, tog) : idle_v;

  // address taken when the later of select and strobe falls
  always @(posedge wr_go) begin
    a_lat = mem_addr;
    ln_lat = ~lane_select_n & ~lane_write_strobe_n;
    t_fall = $realtime;
  end

  // data taken on the first rise; glitches and loads during programming dropped
  always @(negedge wr_go) begin
    if ($realtime - t_fall >= 15.0 && !prog && data_oe) begin
      for (int i = 3; i >= 0; i--) if (ln_lat[i]) b = data_o[8*i+:8];
      if (step != 2'h3 && a_lat == ua[step] && b == ud[step]) step = step + 2'h1;
      else if (step == 2'h3 || !prot) begin
        for (int i = 0; i < 4; i++) if (ln_lat[i]) pb[{a_lat, i[1:0]}] = data_o[8*i+:8];
        last_w = data_o;
        pend = 1'b1;
      end else step = 2'h0;
    end
  end

  // page closes once no strobe fall came within the window, then programs once
  initial forever begin
    wait (pend);
    while ($realtime - t_fall < BLC_NS) #(BLC_NS - ($realtime - t_fall));
    prog = 1'b1;
    #(PROG_NS);
    foreach (pb[k]) mem[k] = pb[k];
    pb.delete();
    if (step == 2'h3) prot = 1'b1;
    {step, pend, prog} = 4'h0;
  end

  // released bus shows the inverse, so a stale value never passes for data
  always @(negedge rd_on) begin
    idle_v = ~rd_word(mem_addr, prog, tog);
    if (prog) tog = ~tog;
  end
endmodule // eema_dev_model

// ==== dv/tb_eema_host.sv ====
// self-checking bench for the eeprom module host controller
`timescale 1ns/1ps
module tb_eema_host;
  localparam int BLC = 40;
  localparam int WC = 2000;
  logic core_clk = 1'b0;
  logic nrst = 1'b0;
  logic req_valid = 1'b0;
  logic req_write = 1'b0;
  logic req_unlock = 1'b0;
  logic req_last = 1'b0;
  logic [16:0] req_addr = 17'h0;
  logic [3:0] req_lanes = 4'h0;
  logic [31:0] req_wdata = 32'h0;
  logic req_ready, rsp_valid, rsp_err, busy, out_enable_n, data_oe, r_err;
  logic [31:0] rsp_rdata, data_o, data_i, r_dat;
  logic [16:0] mem_addr;
  logic [3:0] lane_select_n, lane_write_strobe_n, we_q;
  int errors = 0;
  int tests_run = 0;
  int falls = 0;
  int wlow = 0;
  int r_n = 0;

  always #10 core_clk = ~core_clk;

  eema_host #(.BLC_CYC(BLC), .WC_CYC(WC)) dut (.core_clk, .nrst, .req_valid, .req_ready,
    .req_write, .req_unlock, .req_last, .req_addr, .req_lanes, .req_wdata, .rsp_valid, .rsp_err,
    .rsp_rdata, .busy, .mem_addr, .lane_select_n, .lane_write_strobe_n, .out_enable_n,
    .data_o, .data_oe, .data_i);
  // device window equals the host's: a late join still lands, polling starts after closing
  eema_dev_model #(.BLC_NS(BLC * 20), .PROG_NS(3000)) u_dev (.mem_addr, .lane_select_n,
    .lane_write_strobe_n, .out_enable_n, .data_o, .data_oe, .data_i);

  ////////////////////////////////////////////////////////////////
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      errors++;
      $display("unexpected at %0t: got %08h exp %08h", $time, got, exp);
    end
  endtask

  // request held from just after an edge until the edge that takes it
  task automatic send(input logic w, input logic u, input logic l, input logic [16:0] a,
      input logic [3:0] ln, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge core_clk);
    #1;
    {req_valid, req_write, req_unlock, req_last} = {1'b1, w, u, l};
    {req_addr, req_lanes, req_wdata} = {a, ln, d};
    #1;
    while (req_ready !== 1'b1 && n < 5000) begin
      @(posedge core_clk);
      #1;
      n++;
    end
    check(32'(n < 5000), 32'h1);
    @(posedge core_clk);
    #1;
    req_valid = 1'b0;
  endtask

  task automatic wait_rsp();
    r_n = 0;
    while (rsp_valid !== 1'b1 && r_n < 5000) begin
      @(posedge core_clk);
      #1;
      r_n++;
    end
    {r_err, r_dat} = {rsp_err, rsp_rdata};
    check(32'(r_n < 5000), 32'h1);
  endtask

  task automatic wr1(input logic [16:0] a, input logic [3:0] ln, input logic [31:0] d,
      input logic u, input logic e);
    send(1'b1, u, 1'b1, a, ln, d);
    check({31'h0, busy}, 32'h1);
    wait_rsp();
    check({31'h0, r_err}, {31'h0, e});
  endtask

  // only the selected lanes carry data on a read
  task automatic rd1(input logic [16:0] a, input logic [3:0] ln, input logic [31:0] x);
    logic [31:0] m;
    m = {{8{ln[3]}}, {8{ln[2]}}, {8{ln[1]}}, {8{ln[0]}}};
    send(1'b0, 1'b0, 1'b0, a, ln, 32'h0);
    wait_rsp();
    check({r_err, r_dat[30:0] & m[30:0]}, {1'b0, x[30:0] & m[30:0]});
    check({r_dat[31] & m[31], 29'h0, r_n >= 20, r_n <= 21}, {x[31] & m[31], 29'h0, 2'h3});
  endtask

  ////////////////////////////////////////////////////////////////
  task automatic t_reset();
    check({busy, req_ready, lane_select_n, lane_write_strobe_n, out_enable_n, data_oe},
          32'h7FE);
    $display("test reset done");
  endtask

  task automatic t_byte();
    wr1(17'h00105, 4'h4, 32'h0025_0000, 1'b0, 1'b0);
    rd1(17'h00105, 4'hF, 32'hFF25_FFFF);
    // a read behind an open page waits for programming, then sees the new byte
    send(1'b1, 1'b0, 1'b0, 17'h00106, 4'h1, 32'h0000_00C4);
    rd1(17'h00106, 4'h1, 32'h0000_00C4);
    $display("test byte write done");
  endtask

  task automatic t_page();
    falls = 0;
    send(1'b1, 1'b0, 1'b0, 17'h00200, 4'hF, 32'h1122_3344);
    send(1'b1, 1'b0, 1'b0, 17'h00201, 4'h3, 32'h0000_A5C3);
    send(1'b1, 1'b0, 1'b1, 17'h002FF, 4'hC, 32'h7E81_0000);
    wait_rsp();
    check({31'h0, r_err}, 32'h0);
    check(falls, 3);
    rd1(17'h00200, 4'hF, 32'h1122_3344);
    rd1(17'h00201, 4'h2, 32'h0000_A500);
    rd1(17'h002FF, 4'hC, 32'h7E81_0000);
    $display("test page write done");
  endtask

  task automatic t_lanes();
    send(1'b0, 1'b0, 1'b0, 17'h00010, 4'h5, 32'h0);
    wait_rsp();
    check({29'h0, busy, r_err, r_n <= 2}, 32'h3);
    send(1'b1, 1'b0, 1'b1, 17'h00010, 4'h7, 32'h0);
    wait_rsp();
    check({29'h0, busy, r_err, r_n <= 2}, 32'h3);
    $display("test lane masks done");
  endtask

  task automatic t_protect();
    wr1(17'h00300, 4'h1, 32'h0000_0011, 1'b1, 1'b0);
    rd1(17'h00300, 4'h1, 32'h0000_0011);
    wr1(17'h00300, 4'h1, 32'h0000_0099, 1'b0, 1'b1);
    rd1(17'h00300, 4'h1, 32'h0000_0011);
    wr1(17'h00300, 4'h3, 32'h0000_4277, 1'b1, 1'b0);
    rd1(17'h00300, 4'hF, 32'hFFFF_4277);
    $display("test protection done");
  endtask

  ////////////////////////////////////////////////////////////////
  // pin watcher: strobe only inside a selected lane, output enable high, full width
  always @(posedge core_clk) begin
    we_q <= lane_write_strobe_n;
    if (nrst && lane_write_strobe_n != 4'hF) begin
      wlow <= wlow + 1;
      check({31'h0, out_enable_n}, 32'h1);
      check({28'h0, ~lane_write_strobe_n & lane_select_n}, 32'h0);
      if (we_q == 4'hF) falls <= falls + 1;
    end else if (nrst && we_q != 4'hF) begin
      check(32'(wlow >= eema_pkg::WP_CYC), 32'h1);
      wlow <= 0;
    end
  end

  task automatic test_done();
    $display("checks %0d mismatches %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  initial begin
    repeat (6) @(posedge core_clk);
    #1;
    nrst = 1'b1;
    t_reset();
    t_byte();
    t_page();
    t_lanes();
    t_protect();
    test_done();
  end

  // watchdog: the sequence needs well under 20000 cycles
  initial begin
    #(20000 * 20);
    errors++;
    test_done();
  end
endmodule // tb_eema_host
